/* File: core/sar_adc_sequencer.sv */
// converter sequencer top: registers, modes, triggers and results
// Functional notes
// - resolution is 8 or 10 bits, chosen by software
// - config bit 5 connects the reference ladder when set
// - each result lands in the register of its channel
// - 10-bit result: low 8 bits even byte, top bits odd byte
// - converter clock is base clock undivided, /2 or /4
// - five modes: one-shot, repeat, single sweep, sweep 0, sweep 1
// - mux covers eight standard and two extended inputs
// - software trigger: start flag going to 1 starts
// - external trigger: each falling edge starts or restarts
// - no sample-and-hold: 49 or 59 converter clocks
// - sample-and-hold: 28 or 33 converter clocks
// - one-shot: convert once, interrupt, clear start unless external
// - repeat: convert selected channel until start cleared, no interrupt
// - sweeps over first 2/4/6/8 inputs, single or looped
// - sweep 1 interleaves emphasized inputs before every other standard input
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sequencer
	import adc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [4:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic ext_conversion_trigger_i,
	input wire logic comparator_i,
	output logic ladder_connect_o,
	output logic [3:0] chan_sel_o,
	output logic [9:0] dac_code_o,
	output logic irq_req_o,
	output logic busy_o
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [3:0] first_ch(mode_t m, logic [3:0] ch);
		return (m == M_ONE || m == M_REP) ? ch : 4'h0;
	endfunction
	function automatic logic [3:0] emph_n(logic [1:0] swp);
		return {2'h0, swp} + 4'h1;
	endfunction
	function automatic logic [3:0] grp_last(logic [1:0] swp);
		return {1'b0, swp, 1'b1};
	endfunction

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic start;
		logic ext;
		mode_t mode;
		logic res10;
		logic sh;
		logic refc;
		logic [1:0] div;
		logic [1:0] swp;
		logic [3:0] chan;
		logic [3:0] cur;
		logic [3:0] other;
		logic [NCH-1:0][9:0] res;
		logic [7:0] rdata;
		logic trig;
		logic go;
		logic abort;
		logic irq;
	} st_t;
	st_t q;
	st_t d;
	sar_if s();

	conv_clk_div u_div (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.s(s.clk)
	);
	sar_core u_core (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.s(s.core)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic wm;
		logic stop_wr;
		logic [3:0] emph;
		logic [3:0] last;
		wm = wr_i && addr_i == OFS_MODE;
		stop_wr = wm && !wdata_i[B_START];
		emph = emph_n(q.swp);
		last = grp_last(q.swp);
		d = q;
		d.go = 1'b0;
		d.abort = 1'b0;
		d.irq = 1'b0;
		d.rdata = 8'h00;
		d.trig = ext_conversion_trigger_i;

		// end of one conversion: store, then pick what follows
		if (s.done) begin
			d.res[q.cur] = s.result;
			unique case (q.mode)
				M_ONE: begin
					// hardware clear loses to a same-cycle set below
					d.irq = 1'b1;
					d.start = q.ext;
				end
				M_REP: begin
					d.go = 1'b1;
				end
				M_SSW: begin
					if (q.cur >= last) begin
						d.irq = 1'b1;
						d.start = q.ext;
					end else begin
						d.cur = q.cur + 4'h1;
						d.go = 1'b1;
					end
				end
				M_RSW0: begin
					d.cur = (q.cur >= last) ? 4'h0 : q.cur + 4'h1;
					d.go = 1'b1;
				end
				M_RSW1: begin
					d.go = 1'b1;
					if (q.cur < emph - 4'h1) begin
						d.cur = q.cur + 4'h1;
					end else if (q.cur == emph - 4'h1) begin
						d.cur = q.other;
					end else begin
						d.cur = 4'h0;
						if (q.other >= CH_LAST_STD) begin
							d.other = emph;
						end else begin
							d.other = q.other + 4'h1;
						end
					end
				end
				default: begin
					d.start = 1'b0;
				end
			endcase
		end

		// register writes
		if (wm) begin
			d.ext = wdata_i[B_EXT];
			d.mode = mode_t'(wdata_i[MODE_LSB +: 3]);
			d.start = wdata_i[B_START];
			if (stop_wr) begin
				d.abort = 1'b1;
				d.go = 1'b0;
			end else if (!q.start && !wdata_i[B_EXT]) begin
				d.go = 1'b1;
				d.cur = first_ch(d.mode, q.chan);
				d.other = emph;
			end
		end
		if (wr_i && addr_i == OFS_CFG) begin
			d.res10 = wdata_i[B_RES10];
			d.sh = wdata_i[B_SH];
			d.div = wdata_i[DIV_LSB +: 2];
			d.refc = wdata_i[B_REFC];
			d.swp = wdata_i[SWP_LSB +: 2];
		end
		if (wr_i && addr_i == OFS_CHAN) begin
			// only ten inputs exist, larger codes pick the last one
			if (wdata_i[3:0] > CH_MAX) begin
				d.chan = CH_MAX;
			end else begin
				d.chan = wdata_i[3:0];
			end
		end

		// falling trigger edge restarts even a running sequence
		if (q.start && q.ext && q.trig && !ext_conversion_trigger_i
			&& !stop_wr) begin
			d.go = 1'b1;
			d.cur = first_ch(q.mode, q.chan);
			d.other = emph;
		end

		// register reads, answer stands one cycle
		if (rd_i) begin
			if (addr_i < OFS_MODE) begin
				if (addr_i[0]) begin
					d.rdata = {6'h00, q.res[addr_i[4:1]][9:8]};
				end else begin
					d.rdata = q.res[addr_i[4:1]][7:0];
				end
			end else if (addr_i == OFS_MODE) begin
				d.rdata = {3'h0, q.mode, q.ext, q.start};
			end else if (addr_i == OFS_CFG) begin
				d.rdata = {q.swp, q.refc, 1'b0, q.div, q.sh, q.res10};
			end else if (addr_i == OFS_CHAN) begin
				d.rdata = {4'h0, q.chan};
			end else if (addr_i == OFS_STAT) begin
				d.rdata = {q.cur, 3'h0, s.busy};
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// wiring
	// ****************************************
	assign s.go = q.go;
	assign s.abort = q.abort;
	assign s.res10 = q.res10;
	assign s.sh = q.sh;
	assign s.div = q.div;
	assign s.comp = comparator_i;
	assign rdata_o = q.rdata;
	assign ladder_connect_o = q.refc;
	assign chan_sel_o = q.cur;
	assign dac_code_o = s.dac;
	assign irq_req_o = q.irq;
	assign busy_o = s.busy;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);
	sequence ext_fall;
		q.start && q.ext && q.trig && !ext_conversion_trigger_i;
	endsequence
	sequence no_wr;
		!(wr_i && addr_i == OFS_MODE);
	endsequence
	// plain flag copy of ext_fall, usable where a boolean is needed
	logic fall_now;
	assign fall_now = q.start && q.ext && q.trig && !ext_conversion_trigger_i;
	AST_LADDER: assert property (wr_i && addr_i == OFS_CFG |=>
		ladder_connect_o == $past(wdata_i[B_REFC]))
		else $error("ladder connect does not follow config");
	AST_STORE: assert property (s.done |=>
		q.res[$past(q.cur)] == $past(s.result))
		else $error("result stored in wrong channel");
	AST_SPLIT: assert property (rd_i && addr_i == OFS_RES + 5'h1
		|=> rdata_o == {6'h00, $past(q.res[0][9:8])})
		else $error("upper result bits misplaced");
	AST_SWGO: assert property (wr_i && addr_i == OFS_MODE
		&& wdata_i[B_START] && !wdata_i[B_EXT] && !q.start
		|=> s.go ##1 s.busy)
		else $error("software start lost");
	AST_EXTGO: assert property (ext_fall ##0 no_wr |=>
		s.go ##1 s.busy)
		else $error("external trigger edge ignored");
	AST_ONESHOT: assert property (s.done && q.mode == M_ONE
		&& !q.ext ##0 no_wr |=> irq_req_o && !q.start && !s.go)
		else $error("one-shot end wrong");
	AST_NOIRQ: assert property (irq_req_o |->
		$past(q.mode) == M_ONE || $past(q.mode) == M_SSW)
		else $error("interrupt in a looping mode");
	AST_RSW1: assert property (s.done && q.mode == M_RSW1
		&& q.cur >= emph_n(q.swp) ##0 no_wr ##0 !fall_now
		|=> q.cur == 4'h0 && s.go)
		else $error("emphasized input not interleaved");
	AST_RDIDLE: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data outside its cycle");
	AST_CHCLAMP: assert property (wr_i && addr_i == OFS_CHAN
		&& wdata_i[3:0] > CH_MAX |=> q.chan == CH_MAX)
		else $error("channel code not clamped");
	AST_CHRANGE: assert property (chan_sel_o <= CH_MAX)
		else $error("mux select beyond last input");
	AST_ABORT: assert property (wr_i && addr_i == OFS_MODE
		&& !wdata_i[B_START] |=> s.abort && !s.go ##1 !s.busy)
		else $error("stop write did not abort");
	AST_REPEAT: assert property (s.done && q.mode == M_REP
		##0 no_wr ##0 !fall_now
		|=> s.go && !irq_req_o && q.cur == $past(q.cur))
		else $error("repeat mode did not restart same input");
	AST_SSWEND: assert property (s.done && q.mode == M_SSW
		&& q.cur >= grp_last(q.swp) && !q.ext ##0 no_wr
		|=> irq_req_o && !q.start && !s.go)
		else $error("single sweep end wrong");
	AST_RSW0: assert property (s.done && q.mode == M_RSW0
		&& q.cur >= grp_last(q.swp) ##0 no_wr ##0 !fall_now
		|=> q.cur == 4'h0 && s.go && !irq_req_o)
		else $error("sweep 0 did not wrap");
	AST_RES10: assert property (wr_i && addr_i == OFS_CFG |=>
		s.res10 == $past(wdata_i[B_RES10]))
		else $error("resolution does not follow config");
	AST_DIVSEL: assert property (wr_i && addr_i == OFS_CFG |=>
		s.div == $past(wdata_i[DIV_LSB +: 2]))
		else $error("divider does not follow config");
	AST_EXTKEEP: assert property (s.done && q.mode == M_ONE
		&& q.ext ##0 no_wr |=> irq_req_o && q.start)
		else $error("external one-shot dropped start flag");
endmodule
`default_nettype wire

/* File: core/adc_pkg.sv */
// constants and types shared by the converter sequencer files
package adc_pkg;
	// ****************************************
	// register map, byte addresses, 8-bit data
	// ****************************************
	localparam int NCH = 10;
	localparam logic [4:0] OFS_RES = 5'h00;
	localparam logic [4:0] OFS_MODE = 5'h14;
	localparam logic [4:0] OFS_CFG = 5'h15;
	localparam logic [4:0] OFS_CHAN = 5'h16;
	localparam logic [4:0] OFS_STAT = 5'h17;
	localparam int B_START = 0;
	localparam int B_EXT = 1;
	localparam int MODE_LSB = 2;
	localparam int B_RES10 = 0;
	localparam int B_SH = 1;
	localparam int DIV_LSB = 2;
	localparam int B_REFC = 5;
	localparam int SWP_LSB = 6;
	localparam logic [3:0] CH_MAX = 4'h9;
	localparam logic [3:0] CH_LAST_STD = 4'h7;
	// ****************************************
	// conversion lengths in converter clocks
	// ****************************************
	localparam logic [6:0] CYC_8 = 7'h31;
	localparam logic [6:0] CYC_10 = 7'h3b;
	localparam logic [6:0] CYC_SH8 = 7'h1c;
	localparam logic [6:0] CYC_SH10 = 7'h21;
	localparam logic [9:0] TRIAL_MSB = 10'h200;
	typedef enum logic [2:0] {
		M_ONE = 3'b000,
		M_REP = 3'b001,
		M_SSW = 3'b010,
		M_RSW0 = 3'b011,
		M_RSW1 = 3'b100
	} mode_t;
	typedef enum logic [1:0] {
		DIV_1 = 2'b00,
		DIV_2 = 2'b01,
		DIV_4 = 2'b10
	} div_t;
	function automatic logic [6:0] conv_cycles(logic r10, logic sh);
		if (sh) begin
			return r10 ? CYC_SH10 : CYC_SH8;
		end
		return r10 ? CYC_10 : CYC_8;
	endfunction
	function automatic logic [6:0] res_bits(logic r10);
		return r10 ? 7'h0a : 7'h08;
	endfunction
endpackage

/* File: core/sar_if.sv */
// signals between sequencer, clock divider and approximation core
`timescale 1ns/10ps
`default_nettype none
interface sar_if;
	logic tick;
	logic go;
	logic abort;
	logic res10;
	logic sh;
	logic comp;
	logic busy;
	logic done;
	logic [1:0] div;
	logic [9:0] dac;
	logic [9:0] result;
	modport ctl(output go, abort, res10, sh, div, comp,
		input tick, busy, done, dac, result);
	modport core(input tick, go, abort, res10, sh, comp,
		output busy, done, dac, result);
	modport clk(input div, go, output tick);
endinterface
`default_nettype wire

/* File: core/conv_clk_div.sv */
// converter clock prescaler, one tick pulse per converter clock
`timescale 1ns/10ps
`default_nettype none
module conv_clk_div
	import adc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	sar_if.clk s
);
	typedef struct packed {
		logic [1:0] cnt;
		logic tick;
	} st_t;
	st_t q;
	st_t d;
	always_comb begin
		logic [1:0] lim;
		lim = 2'h3;
		d = q;
		// undivided, /2 or /4 of the base clock
		if (s.div == DIV_1) begin
			lim = 2'h0;
		end else if (s.div == DIV_2) begin
			lim = 2'h1;
		end
		// restart phase so every conversion sees whole periods
		d.cnt = (s.go || q.cnt >= lim) ? 2'h0 : q.cnt + 2'h1;
		d.tick = !s.go && q.cnt >= lim;
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign s.tick = q.tick;
	AST_DIV4: assert property (@(posedge clk_sys_i)
		disable iff (reset_i || s.div != DIV_4)
		s.tick |=> !s.tick [*3])
		else $error("divide-by-4 tick came too early");
endmodule
`default_nettype wire

/* File: core/sar_core.sv */
// successive approximation core: sample phase, then one bit per tick
`timescale 1ns/10ps
`default_nettype none
module sar_core
	import adc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	sar_if.core s
);
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_SAMP = 2'b01,
		S_BITS = 2'b10
	} cst_t;
	typedef struct packed {
		cst_t st;
		logic [6:0] cnt;
		logic [3:0] idx;
		logic [9:0] trial;
		logic [9:0] result;
		logic res10;
		logic sh;
		logic done;
		logic busy;
	} st_t;
	st_t q;
	st_t d;
	logic [6:0] nt_q;
	always_comb begin
		d = q;
		d.done = 1'b0;
		unique case (q.st)
			S_IDLE: begin
			end
			S_SAMP: if (s.tick) begin
				d.cnt = q.cnt - 7'h1;
				if (q.cnt == 7'h1) begin
					// trials start at the top bit
					d.st = S_BITS;
					d.idx = 4'h9;
					d.trial = TRIAL_MSB;
				end
			end
			S_BITS: if (s.tick) begin
				d.trial[q.idx] = s.comp;
				if (q.idx == (q.res10 ? 4'h0 : 4'h2)) begin
					// result only moves once all bits are known
					d.result = q.res10 ? d.trial : {2'h0, d.trial[9:2]};
					d.done = 1'b1;
					d.st = S_IDLE;
				end else begin
					d.idx = q.idx - 4'h1;
					d.trial[q.idx - 4'h1] = 1'b1;
				end
			end
			default: d.st = S_IDLE;
		endcase
		if (s.go) begin
			// length set by resolution and sample-and-hold
			d.st = S_SAMP;
			d.cnt = conv_cycles(s.res10, s.sh) - res_bits(s.res10);
			d.res10 = s.res10;
			d.sh = s.sh;
			d.trial = '0;
		end else if (s.abort) begin
			d.st = S_IDLE;
		end
		d.busy = d.st != S_IDLE;
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign s.busy = q.busy;
	assign s.done = q.done;
	assign s.dac = q.trial;
	assign s.result = q.result;
	// converter clocks since the last start, for checking only
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || s.go) begin
			nt_q <= 7'h00;
		end else if (s.tick && q.busy) begin
			nt_q <= nt_q + 7'h01;
		end
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);
	sequence last_samp;
		q.st == S_SAMP && s.tick && q.cnt == 7'h1 && !s.go && !s.abort;
	endsequence
	sequence bit_step;
		q.st == S_BITS && s.tick && !s.go && !s.abort && q.idx > 4'h2;
	endsequence
	AST_CYC: assert property (s.done |->
		nt_q == conv_cycles(q.res10, q.sh))
		else $error("conversion length wrong");
	AST_MSB: assert property (last_samp |=>
		q.st == S_BITS && q.trial == TRIAL_MSB && q.idx == 4'h9)
		else $error("trial did not start at top bit");
	AST_ORDER: assert property (bit_step |=>
		q.idx == $past(q.idx) - 4'h1 && !s.done)
		else $error("bit order broken");
	AST_HOLD: assert property ($changed(s.result) |-> s.done)
		else $error("result moved mid conversion");
endmodule
`default_nettype wire

/* File: verif/analog_source.sv */
// analog input and trigger source model facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module analog_source (
	input wire logic clk_sys_i,
	input wire logic [3:0] chan_sel_i,
	input wire logic [9:0] dac_code_i,
	output logic comparator_o,
	output var logic trig_o
);
	// ********
	// fixed level per input, distinct bit patterns
	// ********
	function automatic logic [9:0] level(input logic [3:0] ch);
		return {ch, 6'h2d} ^ 10'h155;
	endfunction
	// comparator reads back the mux select and dac code, and compares that input's level with the trial code
	assign comparator_o = (level(chan_sel_i) >= dac_code_i);
	initial trig_o = 1'b1;
	// trigger idles high, so only this pulse makes a falling edge
	task automatic fall();
		@(posedge clk_sys_i);
		trig_o <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		trig_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* File: verif/sar_adc_sequencer_bench.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sequencer_bench
	import adc_pkg::*;
;
	logic clk_sys_i, reset_i, wr_i, rd_i, trig, comp, bad;
	logic [4:0] addr_i;
	logic [7:0] wdata_i, rdata_o;
	logic ladder_connect_o, irq_req_o, busy_o;
	logic [3:0] chan_sel_o;
	logic [9:0] dac_code_o, dac_first, prev;
	logic [3:0] seq [6];
	int err_count, n_checks, irq_n, n, m, j;
	// ********
	// one-shot table: channel, config, length, divider
	// ********
	// dividers keep the converter clock above its minimum rate
	logic [3:0] t_ch [4] = '{4'h3, 4'h9, 4'h8, 4'h0};
	logic [7:0] t_cfg [4] = '{8'h20, 8'h21, 8'h26, 8'h2b};
	int t_n [4] = '{49, 59, 28, 33};
	int t_k [4] = '{1, 1, 2, 4};
	logic [3:0] t_sw1 [6] = '{4'h0, 4'h1, 4'h0, 4'h2, 4'h0, 4'h3};
	sar_adc_sequencer dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .ext_conversion_trigger_i(trig),
		.comparator_i(comp), .ladder_connect_o(ladder_connect_o),
		.chan_sel_o(chan_sel_o), .dac_code_o(dac_code_o),
		.irq_req_o(irq_req_o), .busy_o(busy_o));
	analog_source src (.clk_sys_i(clk_sys_i), .chan_sel_i(chan_sel_o),
		.dac_code_i(dac_code_o), .comparator_o(comp), .trig_o(trig));
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	// first trial code seen while busy, and a count of pulses
	always @(posedge clk_sys_i) begin
		if (irq_req_o === 1'b1) irq_n++;
		if (busy_o === 1'b1 && dac_first === 10'h0) dac_first <= dac_code_o;
	end
	// ********
	// tasks
	// ********
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 check(rdata_o, e);
	endtask
	task automatic wait_cyc(input int k);
		repeat (k) @(posedge clk_sys_i);
		#1;
	endtask
	// bounded wait; running out ends the run as a failure
	task automatic wait_irq(input int lim);
		n = 0;
		while (irq_req_o !== 1'b1) begin
			@(posedge clk_sys_i);
			#1 n++;
			if (n > lim) begin
				err_count++;
				finish_test();
			end
		end
	endtask
	task automatic res_chk(input logic [3:0] ch, input logic r10);
		logic [9:0] v;
		v = src.level(ch);
		rd_chk({ch, 1'b0}, r10 ? v[7:0] : v[9:2]);
		rd_chk({ch, 1'b1}, r10 ? {6'h00, v[9:8]} : 8'h00);
	endtask
	// ********
	// main sequence
	// ********
	initial begin
		reset_i = 1'b1;
		addr_i = 5'h00;
		wdata_i = 8'h00;
		wr_i = 1'b0;
		rd_i = 1'b0;
		repeat (12) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		rd_chk(OFS_MODE, 8'h00);
		rd_chk(OFS_CFG, 8'h00);
		wr(5'h18, 8'h5a);
		rd_chk(5'h18, 8'h00);
		wr(OFS_CHAN, 8'h0c);
		rd_chk(OFS_CHAN, 8'h09);
		check(ladder_connect_o, 1'b0);
		wr(OFS_CFG, 8'h20);
		#1 check(ladder_connect_o, 1'b1);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CHAN, {4'h0, t_ch[i]});
			wr(OFS_CFG, t_cfg[i]);
			dac_first = 10'h000;
			wr(OFS_MODE, 8'h01);
			wait_irq(2000);
			m = t_n[i] * t_k[i];
			check(n > m && n <= m + t_k[i] + 4, 1'b1);
			check(dac_first, TRIAL_MSB);
			res_chk(t_ch[i], t_cfg[i][0]);
			rd_chk(OFS_MODE, 8'h00);
		end
		// abort in mid-conversion leaves the old result alone
		wr(OFS_CHAN, 8'h05);
		wr(OFS_CFG, 8'h20);
		m = irq_n;
		wr(OFS_MODE, 8'h01);
		wait_cyc(20);
		wr(OFS_MODE, 8'h00);
		wait_cyc(4);
		check(busy_o, 1'b0);
		check(irq_n, m);
		rd_chk(5'h0a, 8'h00);
		wr(OFS_CHAN, 8'h01);
		wr(OFS_MODE, 8'h05);
		wait_cyc(200);
		check(irq_n, m);
		rd_chk(OFS_MODE, 8'h05);
		res_chk(4'h1, 1'b0);
		wr(OFS_MODE, 8'h04);
		wait_cyc(4);
		check(busy_o, 1'b0);
		wr(OFS_CFG, 8'h60);
		wr(OFS_MODE, 8'h09);
		wait_irq(1000);
		wait_cyc(100);
		check(irq_n, m + 1);
		for (int c = 0; c < 4; c++) res_chk(c[3:0], 1'b0);
		rd_chk(5'h08, 8'h00);
		wr(OFS_CFG, 8'h20);
		wr(OFS_MODE, 8'h0d);
		wait_cyc(4);
		bad = 1'b0;
		repeat (400) begin
			@(posedge clk_sys_i);
			#1;
			if (chan_sel_o > 4'h1) bad = 1'b1;
		end
		check(bad, 1'b0);
		check(irq_n, m + 1);
		wr(OFS_MODE, 8'h0c);
		wait_cyc(4);
		wr(OFS_MODE, 8'h11);
		j = 0;
		prev = 10'h000;
		for (int c = 0; c < 2000 && j < 6; c++) begin
			@(posedge clk_sys_i);
			#1;
			if (dac_code_o === TRIAL_MSB && prev !== TRIAL_MSB) begin
				seq[j] = chan_sel_o;
				j++;
			end
			prev = dac_code_o;
		end
		for (int c = 0; c < 6; c++) check(seq[c], t_sw1[c]);
		wr(OFS_MODE, 8'h10);
		wr(OFS_CHAN, 8'h06);
		wr(OFS_MODE, 8'h03);
		wait_cyc(10);
		check(busy_o, 1'b0);
		src.fall();
		wait_cyc(20);
		check(busy_o, 1'b1);
		src.fall();
		wait_irq(1000);
		check(n > 40, 1'b1);
		rd_chk(OFS_MODE, 8'h03);
		res_chk(4'h6, 1'b0);
		wr(OFS_MODE, 8'h02);
		finish_test();
	end
endmodule
`default_nettype wire
